/* bench/acd_bus_master.sv */
// Purpose: Two-wire bus master model that drives the command decoder
// Assumes: Open-drain lines with pull-ups; bit timing set by quarter
// Notes:   Bus clock stands high between frames; quarter can be raised for a slow master
`timescale 1ns/1ps
module acd_bus_master #(
  parameter logic [6:0] ADDR = 7'h2a  // Arbitrary bus address
) (
  input  wire logic clk,
  input  wire logic sda_dev_oe,
  output logic      scl,
  output logic      sda
);
  logic drive_low;
  int   quarter = 6;  // Clocks per quarter bit, well above the decoder's sync delay

  // Wired-and data line: the pull-up wins unless either party pulls low
  assign sda = !(drive_low || sda_dev_oe);

  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    drive_low = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n * quarter) @(posedge clk);
    #1;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    drive_low = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    drive_low = 1'b1;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask

  // Data changes only while the clock is low
  task automatic bit_out(input logic b);
    drive_low = !b;
    wait_q(1);
    scl = 1'b1;
    wait_q(2);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic bit_in(output logic v);
    drive_low = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    v = sda;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(nak);
    ack = !nak;
  endtask

  task automatic stop_cond();
    drive_low = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    drive_low = 1'b0;
    wait_q(2);
  endtask

  task automatic write(input logic [6:0] a, input logic [7:0] cmd, input logic has_p,
                       input logic [7:0] p, input logic do_stop, output logic ack);
    logic a1;
    start_cond();
    put_byte({a, 1'b0}, ack);
    put_byte(cmd, a1);
    if (has_p) put_byte(p, a1);
    if (do_stop) stop_cond();
  endtask

  task automatic read(input logic [7:0] cmd, output logic [7:0] data);
    logic a1;
    start_cond();
    put_byte({ADDR, 1'b0}, a1);
    put_byte(cmd, a1);
    start_cond();
    put_byte({ADDR, 1'b1}, a1);
    for (int i = 7; i >= 0; i--) bit_in(data[i]);
    bit_out(1'b1);  // Nack ends the read
    stop_cond();
  endtask
endmodule // acd_bus_master

/* bench/tb.sv */
// Purpose: Self-checking bench for the sensor front-end command decoder
// Assumes: acd_bus_master plays the bus master; 40 MHz system clock
// Notes:   Outputs are judged after each transfer has settled
`timescale 1ns/1ps
module tb;
  import acd_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;  // Arbitrary bus address
  localparam logic [9:0] GAINS [8] = '{10'h002, 10'h014, 10'h028, 10'h050,
                                       10'h096, 10'h12c, 10'h258, 10'h2f8};
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  scl;
  logic                  sda;
  logic                  sda_out;
  logic                  sda_oe;
  logic                  analog_sleep;
  logic [GAIN_W-1:0]     gain_code;
  logic [GAIN_VAL_W-1:0] gain_value;
  logic                  supply_low_level;
  logic                  regulator_on;
  logic                  current_monitor_on;
  logic [CHAN_W-1:0]     channel_sel;
  logic                  ack;
  logic [7:0]            rd;
  int                    fail_count = 0;
  int                    num_checks = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  acd_command_decoder #(.DEV_ADDR(DEV)) u_dut (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .analog_sleep(analog_sleep), .gain_code(gain_code),
    .gain_value(gain_value), .supply_low_level(supply_low_level),
    .regulator_on(regulator_on), .current_monitor_on(current_monitor_on),
    .channel_sel(channel_sel));

  acd_bus_master #(.ADDR(DEV)) u_master (
    .clk(clk), .sda_dev_oe(sda_oe), .scl(scl), .sda(sda));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Full write with stop; only the address byte must be acknowledged, later acks are discarded
  task automatic wr(input logic [7:0] cmd, input logic has_p, input logic [7:0] p);
    u_master.write(DEV, cmd, has_p, p, 1'b1, ack);
    check(16'(ack), 16'h0001);
  endtask

  task automatic t_reset();
    check(16'(sda_oe), 16'h0000);
    check(16'(sda_out), 16'h0000);
    check(16'(analog_sleep), 16'h0000);
    check(16'(channel_sel), 16'h0000);
    check(16'(gain_code), 16'h0000);
    check(16'(gain_value), 16'h0002);
    check(16'(supply_low_level), 16'h0000);
    check(16'(regulator_on), 16'h0001);
    check(16'(current_monitor_on), 16'h0000);
    $display("Test reset done");
  endtask

  task automatic t_gain();
    for (int i = 0; i < 8; i++) begin
      wr(REG_GAIN, 1'b1, 8'(i));
      check(16'(gain_code), 16'(i));
      check(16'(gain_value), 16'(GAINS[i]));
    end
    wr(REG_GAIN, 1'b1, 8'hfd);
    u_master.read(REG_GAIN, rd);
    check(16'(rd), 16'h0005);
    $display("Test gain done");
  endtask

  // Each channel code acts at the end of its byte, before any stop
  task automatic t_chan();
    for (int i = 0; i < 16; i++) begin
      u_master.write(DEV, CMD_CHAN_FIRST + 8'(i), 1'b0, 8'h00, 1'b0, ack);
      check(16'(channel_sel), 16'(i));
      u_master.stop_cond();
    end
    u_master.write(7'h15, CMD_CHAN_FIRST, 1'b0, 8'h00, 1'b1, ack);
    check(16'(ack), 16'h0000);
    check(16'(channel_sel), 16'h000f);
    $display("Test channel done");
  endtask

  // Slow master here, to show the decoder does not rely on bus rate
  task automatic t_sleep();
    u_master.quarter = 12;
    wr(REG_SUPPLY, 1'b1, 8'h03);
    check(16'(supply_low_level), 16'h0001);
    check(16'(regulator_on), 16'h0001);
    wr(CMD_SLEEP, 1'b0, 8'h00);
    check(16'(analog_sleep), 16'h0001);
    check(16'(regulator_on), 16'h0000);
    wr(REG_GAIN, 1'b1, 8'h02);
    wr(CMD_CHAN_FIRST + 8'h05, 1'b0, 8'h00);
    wr(CMD_CUR_MON, 1'b0, 8'h00);
    check(16'(gain_code), 16'h0005);
    check(16'(channel_sel), 16'h000f);
    check(16'(current_monitor_on), 16'h0000);
    u_master.read(REG_SUPPLY, rd);
    check(16'(rd), 16'h0000);
    wr(CMD_WAKE, 1'b0, 8'h00);
    check(16'(analog_sleep), 16'h0000);
    check(16'(regulator_on), 16'h0001);
    wr(REG_SUPPLY, 1'b1, 8'h01);
    wr(CMD_SLEEP, 1'b0, 8'h00);
    check(16'(regulator_on), 16'h0001);
    wr(CMD_WAKE, 1'b0, 8'h00);
    u_master.quarter = 6;
    $display("Test sleep done");
  endtask

  task automatic t_cur_mon();
    wr(CMD_CUR_MON, 1'b0, 8'h00);
    check(16'(current_monitor_on), 16'h0001);
    check(16'(channel_sel), 16'h000f);
    wr(8'h13, 1'b1, 8'h02);
    check(16'(current_monitor_on), 16'h0000);
    check(16'(channel_sel), 16'h0003);
    check(16'(gain_code), 16'h0005);
    wr(CMD_CUR_MON, 1'b0, 8'h00);
    wr(CMD_CHAN_LAST, 1'b0, 8'h00);
    check(16'(current_monitor_on), 16'h0000);
    $display("Test current monitor done");
  endtask

  task automatic t_restart();
    wr(REG_GAIN, 1'b1, 8'h07);
    wr(REG_SUPPLY, 1'b1, 8'h03);
    wr(CMD_CUR_MON, 1'b0, 8'h00);
    wr(CMD_SW_RESTART, 1'b0, 8'h00);
    check(16'(gain_code), 16'h0000);
    check(16'(channel_sel), 16'h0000);
    check(16'(current_monitor_on), 16'h0000);
    check(16'(analog_sleep), 16'h0000);
    check(16'(gain_value), 16'h0002);
    check(16'(supply_low_level), 16'h0000);
    u_master.read(REG_SUPPLY, rd);
    check(16'(rd), 16'h0000);
    $display("Test restart done");
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_gain();
    t_chan();
    t_sleep();
    t_cur_mon();
    t_restart();
    final_report();
  end

  // Watchdog: about two and a half times the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // tb

/* src/acd_byte_if.sv */
// Purpose: Byte hand-off between the bus engine and the command decoder
// Assumes: Single clock; all signals registered by their driver
// Notes:   rx_valid and tx_load are one-cycle pulses
`timescale 1ns/1ps
interface acd_byte_if;
  logic       rx_valid;
  logic       rx_first;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic       tx_load;
  modport link (output rx_valid, output rx_first, output rx_byte, output tx_load,
                input tx_byte);
  modport dec  (input rx_valid, input rx_first, input rx_byte, input tx_load,
                output tx_byte);
endinterface

/* src/acd_command_decoder.sv */
// Purpose: Command decoder for a sixteen-channel sensor front end on a two-wire bus
// Assumes: Bus engine delivers whole bytes; first byte of a write is the command
// Notes:   Analog side is driven by levels only; settling is outside this block
`timescale 1ns/1ps
module acd_command_decoder
  import acd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary default bus address
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  output logic                       analog_sleep,
  output logic [GAIN_W-1:0]          gain_code,
  output logic [GAIN_VAL_W-1:0]      gain_value,
  output logic                       supply_low_level,
  output logic                       regulator_on,
  output logic                       current_monitor_on,
  output logic [CHAN_W-1:0]          channel_sel
);
  acd_byte_if bus ();

  logic                  sleep_r, sleep_nxt;
  logic [GAIN_W-1:0]     gain_r, gain_nxt;
  logic [SUPPLY_W-1:0]   supply_r, supply_nxt;
  logic                  cur_r, cur_nxt;
  logic [CHAN_W-1:0]     chan_r, chan_nxt;
  logic [7:0]            ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic                  reg_on_r, reg_on_nxt;
  logic [GAIN_VAL_W-1:0] gval_r, gval_nxt;
  logic                  cmd_seen, prm_seen, cmd_taken;
  // Reset gain value fixed at elaboration, so the reset branch loads a constant
  localparam logic [GAIN_VAL_W-1:0] GVAL_RST = acd_gain_of(GAIN_RST);

  acd_i2c_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .clk     (clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .bus     (bus)
  );

  // Command byte is the first data byte of a write; later bytes are parameters
  assign cmd_seen  = bus.rx_valid & bus.rx_first;
  assign prm_seen  = bus.rx_valid & ~bus.rx_first;
  assign cmd_taken = cmd_seen & (~sleep_r | (bus.rx_byte == CMD_WAKE));

  // Decode acts on the byte-complete pulse itself, so commands need no stop
  always_comb begin
    sleep_nxt  = sleep_r;
    gain_nxt   = gain_r;
    supply_nxt = supply_r;
    cur_nxt    = cur_r;
    chan_nxt   = chan_r;
    ptr_nxt    = ptr_r;
    if (cmd_taken) begin
      ptr_nxt = bus.rx_byte;
      case (bus.rx_byte)
        CMD_SW_RESTART: begin
          sleep_nxt  = 1'b0;
          gain_nxt   = GAIN_RST;
          supply_nxt = SUPPLY_RST;
          cur_nxt    = 1'b0;
          chan_nxt   = CHAN_RST;
        end
        CMD_WAKE:    sleep_nxt = 1'b0;
        CMD_SLEEP:   sleep_nxt = 1'b1;
        CMD_CUR_MON: cur_nxt   = 1'b1;
        default: if (acd_is_chan(bus.rx_byte)) begin
          chan_nxt = bus.rx_byte[CHAN_W-1:0];
          cur_nxt  = 1'b0;
        end
      endcase
    end else if (prm_seen && !sleep_r) begin
      // Bytes land only in the register named by the last accepted command
      case (ptr_r)
        REG_GAIN:   gain_nxt   = bus.rx_byte[GAIN_W-1:0];
        REG_SUPPLY: supply_nxt = bus.rx_byte[SUPPLY_W-1:0];
        default:    ;
      endcase
    end
  end

  // Derived outputs are computed from next state so they move with it
  always_comb begin
    reg_on_nxt = ~sleep_nxt | ~supply_nxt[SUPPLY_OFF_BIT];
    gval_nxt   = acd_gain_of(gain_nxt);
    tx_nxt     = BYTE_ZERO;
    // Reads while asleep return zero, since register addresses are ignored
    if (!sleep_nxt) begin
      case (ptr_nxt)
        REG_GAIN:   tx_nxt = {{(8-GAIN_W){1'b0}}, gain_nxt};
        REG_SUPPLY: tx_nxt = {{(8-SUPPLY_W){1'b0}}, supply_nxt};
        default:    tx_nxt = BYTE_ZERO;
      endcase
    end
  end

  // Power-up: active, channel zero, current sense off, defaults everywhere
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_r  <= 1'b0;
      gain_r   <= GAIN_RST;
      supply_r <= SUPPLY_RST;
      cur_r    <= 1'b0;
      chan_r   <= CHAN_RST;
      ptr_r    <= BYTE_ZERO;
      tx_r     <= BYTE_ZERO;
      reg_on_r <= 1'b1;
      gval_r   <= GVAL_RST;
    end else begin
      sleep_r  <= sleep_nxt;
      gain_r   <= gain_nxt;
      supply_r <= supply_nxt;
      cur_r    <= cur_nxt;
      chan_r   <= chan_nxt;
      ptr_r    <= ptr_nxt;
      tx_r     <= tx_nxt;
      reg_on_r <= reg_on_nxt;
      gval_r   <= gval_nxt;
    end
  end

  assign bus.tx_byte        = tx_r;
  assign analog_sleep       = sleep_r;
  assign gain_code          = gain_r;
  assign gain_value         = gval_r;
  assign supply_low_level   = supply_r[SUPPLY_LOW_BIT];
  assign regulator_on       = reg_on_r;
  assign current_monitor_on = cur_r;
  assign channel_sel        = chan_r;

  // Checks
  sequence s_cmd(logic [7:0] code);
    cmd_seen && bus.rx_byte == code && !sleep_r;
  endsequence
  sequence s_param(logic [7:0] reg_off);
    prm_seen && ptr_r == reg_off && !sleep_r;
  endsequence

  chk_wake_cmd: assert property (@(posedge clk) disable iff (reset)
    cmd_seen && bus.rx_byte == CMD_WAKE |=> !analog_sleep ##1 !analog_sleep)
    else $error("Wake code did not return to active");
  chk_sleep_cmd: assert property (@(posedge clk) disable iff (reset)
    s_cmd(CMD_SLEEP) |=> analog_sleep && regulator_on == !supply_r[SUPPLY_OFF_BIT])
    else $error("Sleep code did not enter sleep");
  chk_sleep_ignore: assert property (@(posedge clk) disable iff (reset)
    sleep_r && cmd_seen && bus.rx_byte != CMD_WAKE
      |=> analog_sleep && $stable(channel_sel) && $stable(current_monitor_on))
    else $error("Command acted upon while asleep");
  chk_sleep_param: assert property (@(posedge clk) disable iff (reset)
    sleep_r && prm_seen |=> $stable(gain_code) && $stable(supply_r))
    else $error("Parameter byte written while asleep");
  chk_gain_write: assert property (@(posedge clk) disable iff (reset)
    s_param(REG_GAIN) |=> gain_code == $past(bus.rx_byte[GAIN_W-1:0]))
    else $error("Gain write not stored");
  chk_supply_write: assert property (@(posedge clk) disable iff (reset)
    s_param(REG_SUPPLY) |=> supply_low_level == $past(bus.rx_byte[SUPPLY_LOW_BIT]))
    else $error("Supply level write not stored");
  chk_reg_sleep: assert property (@(posedge clk) disable iff (reset)
    analog_sleep |-> regulator_on == !supply_r[SUPPLY_OFF_BIT])
    else $error("Regulator state wrong in sleep");
  chk_reg_active: assert property (@(posedge clk) disable iff (reset)
    !analog_sleep |-> regulator_on)
    else $error("Regulator off while active");
  chk_cur_enter: assert property (@(posedge clk) disable iff (reset)
    s_cmd(CMD_CUR_MON) |=> current_monitor_on)
    else $error("Current sense not entered");
  chk_cur_exit: assert property (@(posedge clk) disable iff (reset)
    cmd_seen && !sleep_r && acd_is_chan(bus.rx_byte) |=> !current_monitor_on)
    else $error("Channel select did not end current sense");
  chk_chan_sel: assert property (@(posedge clk) disable iff (reset)
    cmd_seen && !sleep_r && acd_is_chan(bus.rx_byte)
      |=> channel_sel == $past(bus.rx_byte) - CMD_CHAN_FIRST)
    else $error("Wrong channel selected");
  chk_gain_map: assert property (@(posedge clk) disable iff (reset)
    $changed(gain_code) |-> gain_value == acd_gain_of(gain_code))
    else $error("Gain value does not match code");
  chk_sw_restart: assert property (@(posedge clk) disable iff (reset)
    s_cmd(CMD_SW_RESTART) |=> gain_code == GAIN_RST && supply_r == SUPPLY_RST
      && channel_sel == CHAN_RST && !current_monitor_on && regulator_on)
    else $error("Software restart left a register changed");
  chk_powerup: assert property (@(posedge clk)
    $fell(reset) |-> channel_sel == CHAN_RST && !analog_sleep && !current_monitor_on)
    else $error("Power-up state wrong");
  // Read path, sleep holding, current-sense channel hold and supply-off bit storage; a read loaded while asleep must carry nothing
  chk_read_upper: assert property (@(posedge clk) disable iff (reset)
    bus.tx_load |-> (bus.tx_byte >> GAIN_W) == BYTE_ZERO)
    else $error("Read data has upper bits set");
  chk_read_asleep: assert property (@(posedge clk) disable iff (reset)
    bus.tx_load && analog_sleep |-> bus.tx_byte == BYTE_ZERO)
    else $error("Register read answered while asleep");
  chk_sleep_hold: assert property (@(posedge clk) disable iff (reset)
    analog_sleep && !(cmd_seen && bus.rx_byte == CMD_WAKE) |=> analog_sleep)
    else $error("Left sleep without the wake code");
  chk_cur_chan: assert property (@(posedge clk) disable iff (reset)
    s_cmd(CMD_CUR_MON) |=> $stable(channel_sel))
    else $error("Current sense moved the channel");
  chk_supply_off: assert property (@(posedge clk) disable iff (reset)
    s_param(REG_SUPPLY) |=> supply_r[SUPPLY_OFF_BIT] == $past(bus.rx_byte[SUPPLY_OFF_BIT]))
    else $error("Regulator disable bit not stored");
endmodule // acd_command_decoder

/* src/acd_i2c_link.sv */
// Purpose: Two-wire bus slave byte engine: start/stop, address match, ack, shift
// Assumes: Bus lines are asynchronous and sampled well above the bus rate
// Notes:   Data bytes are always acknowledged; reads repeat the current tx_byte
`timescale 1ns/1ps
module acd_i2c_link
  import acd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary default
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  acd_byte_if.link  bus
);
  typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK_WAIT, L_ACK, L_TX, L_TX_ACK} acd_link_t;

  logic [1:0] scl_s_r, sda_s_r;
  logic       scl_d_r, sda_d_r;
  acd_link_t  st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, rxb_r, rxb_nxt;
  logic       addr_r, addr_nxt, first_r, first_nxt, read_r, read_nxt;
  logic       ack_r, ack_nxt, oe_r, oe_nxt, rxv_r, rxv_nxt, rxf_r, rxf_nxt;
  logic       txl_r, txl_nxt, nak_r, nak_nxt;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  // Two-stage synchronisers; edges only look at the second stage and its copy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl_rise  = scl_s_r[1] & ~scl_d_r;
  assign scl_fall  = ~scl_s_r[1] & scl_d_r;
  assign bus_start = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  assign bus_stop  = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

  // Bit sequencer; start and stop override any state
  always_comb begin
    st_nxt = st_r; cnt_nxt = cnt_r; sh_nxt = sh_r; rxb_nxt = rxb_r;
    addr_nxt = addr_r; first_nxt = first_r; read_nxt = read_r; ack_nxt = ack_r;
    oe_nxt = oe_r; rxf_nxt = rxf_r; nak_nxt = nak_r;
    rxv_nxt = 1'b0;
    txl_nxt = 1'b0;
    if (bus_start) begin
      st_nxt = L_RX; cnt_nxt = 3'h0; addr_nxt = 1'b1; first_nxt = 1'b1; oe_nxt = 1'b0;
    end else if (bus_stop) begin
      st_nxt = L_IDLE; oe_nxt = 1'b0;
    end else begin
      case (st_r)
        L_RX: if (scl_rise) begin
          sh_nxt  = {sh_r[6:0], sda_s_r[1]};
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == BIT_LAST) begin
            st_nxt = L_ACK_WAIT;
            if (addr_r) begin
              ack_nxt  = (sh_r[6:0] == DEV_ADDR);
              read_nxt = sda_s_r[1];
            end else begin
              ack_nxt   = 1'b1;
              rxv_nxt   = 1'b1;
              rxb_nxt   = {sh_r[6:0], sda_s_r[1]};
              rxf_nxt   = first_r;
              first_nxt = 1'b0;
            end
          end
        end
        L_ACK_WAIT: if (scl_fall) begin
          oe_nxt = ack_r;                 // Pull low to acknowledge
          st_nxt = ack_r ? L_ACK : L_IDLE;
        end
        L_ACK, L_TX_ACK: if (st_r == L_TX_ACK && scl_rise) begin
          nak_nxt = sda_s_r[1];
        end else if (scl_fall) begin
          addr_nxt = 1'b0;
          cnt_nxt  = 3'h0;
          if (st_r == L_TX_ACK && nak_r) begin
            st_nxt = L_IDLE;
            oe_nxt = 1'b0;
          end else if (read_r) begin
            sh_nxt  = bus.tx_byte;
            txl_nxt = 1'b1;
            oe_nxt  = ~bus.tx_byte[7];
            st_nxt  = L_TX;
          end else begin
            oe_nxt = 1'b0;
            st_nxt = L_RX;
          end
        end
        L_TX: if (scl_fall) begin
          cnt_nxt = cnt_r + 3'h1;
          sh_nxt  = {sh_r[6:0], 1'b0};
          oe_nxt  = (cnt_r == BIT_LAST) ? 1'b0 : ~sh_r[6];
          nak_nxt = 1'b0;
          if (cnt_r == BIT_LAST) st_nxt = L_TX_ACK;
        end
        default: st_nxt = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= L_IDLE; cnt_r <= 3'h0; sh_r <= BYTE_ZERO; rxb_r <= BYTE_ZERO;
      addr_r <= 1'b0; first_r <= 1'b0; read_r <= 1'b0; ack_r <= 1'b0;
      oe_r <= 1'b0; rxv_r <= 1'b0; rxf_r <= 1'b0; txl_r <= 1'b0; nak_r <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      st_r <= st_nxt; cnt_r <= cnt_nxt; sh_r <= sh_nxt; rxb_r <= rxb_nxt;
      addr_r <= addr_nxt; first_r <= first_nxt; read_r <= read_nxt; ack_r <= ack_nxt;
      oe_r <= oe_nxt; rxv_r <= rxv_nxt; rxf_r <= rxf_nxt; txl_r <= txl_nxt;
      nak_r <= nak_nxt;
      sda_out <= 1'b0;                    // Open drain: only ever pulls low
    end
  end

  assign sda_oe       = oe_r;
  assign bus.rx_valid = rxv_r;
  assign bus.rx_first = rxf_r;
  assign bus.rx_byte  = rxb_r;
  assign bus.tx_load  = txl_r;
endmodule // acd_i2c_link

/* src/acd_pkg.sv */
// Purpose: Shared constants and helpers for the sensor front-end command decoder
// Assumes: Command and register codes are 8-bit bytes on the two-wire bus
// Notes:   Gain table returns the amplifier gain as a plain number in V/V
package acd_pkg;
  // Command codes with no parameter byte
  localparam logic [7:0] CMD_SW_RESTART = 8'h01;
  localparam logic [7:0] CMD_WAKE       = 8'h04;
  localparam logic [7:0] CMD_SLEEP      = 8'h05;
  localparam logic [7:0] CMD_CUR_MON    = 8'h08;
  localparam logic [7:0] CMD_CHAN_FIRST = 8'h10;
  localparam logic [7:0] CMD_CHAN_LAST  = 8'h1f;
  // Register offsets, one parameter byte each
  localparam logic [7:0] REG_GAIN       = 8'h06;
  localparam logic [7:0] REG_SUPPLY     = 8'h07;
  // Field layout and reset values
  localparam int         GAIN_W         = 3;
  localparam int         SUPPLY_W       = 2;
  localparam int         SUPPLY_LOW_BIT = 0;
  localparam int         SUPPLY_OFF_BIT = 1;
  localparam int         CHAN_W         = 4;
  localparam int         GAIN_VAL_W     = 10;
  localparam logic [GAIN_W-1:0]   GAIN_RST   = 3'h0;
  localparam logic [SUPPLY_W-1:0] SUPPLY_RST = 2'h0;
  localparam logic [CHAN_W-1:0]   CHAN_RST   = 4'h0;
  localparam logic [7:0]          BYTE_ZERO  = 8'h00;
  localparam logic [2:0]          BIT_LAST   = 3'h7;

  // Amplifier gain selected by each code
  function automatic logic [GAIN_VAL_W-1:0] acd_gain_of(input logic [GAIN_W-1:0] code);
    case (code)
      3'h0:    acd_gain_of = 10'h002;
      3'h1:    acd_gain_of = 10'h014;
      3'h2:    acd_gain_of = 10'h028;
      3'h3:    acd_gain_of = 10'h050;
      3'h4:    acd_gain_of = 10'h096;
      3'h5:    acd_gain_of = 10'h12c;
      3'h6:    acd_gain_of = 10'h258;
      default: acd_gain_of = 10'h2f8;
    endcase
  endfunction

  // True for one of the sixteen channel-select codes
  function automatic logic acd_is_chan(input logic [7:0] code);
    acd_is_chan = (code >= CMD_CHAN_FIRST) && (code <= CMD_CHAN_LAST);
  endfunction
endpackage
